// ===== rtl/pfcp_card.v
// Behaviour
// - Input mode waiting: strobe driven high
// - Output: drive word, strobe after T1
// - Input: flag edge, wait T2, latch, drop strobe
// - Input: re-raise after T3 and FIFO room
// - Output: flag edge drops strobe, next word waits data
// - Flag rising edge triggers; falling if edge bit
// - Subchannel is device; commands dropped; status AES
// - Byte and end indications never asserted
// - Read and write orders ignored
// - Poll answered only when data path ready
// - Self test always reports pass
// - Always ready for command; content ignored
// - Four qualifier lines decode read registers
// - Undecoded write changes nothing
// - Undecoded read value unspecified
// - Dormant after reset; unit-address data write wakes
// - Host word msb on output bit fifteen
// - No byte packing; full word every access
// - Sense readable once awake; request bits live
// - Control enables interrupts, clears this card
`timescale 1ns/10ps
`include "pfcp_regs.vh"

module pfcp_card #(
  parameter DATA_W      = 16,
  parameter FIFO_DEPTH  = 16,
  parameter FIFO_AW     = 4,
  parameter T1_SHORT_NS = 140,
  parameter T1_LONG_NS  = 300,
  parameter T2_SHORT_NS = 40,
  parameter T2_LONG_NS  = 100,
  parameter T3_SHORT_NS = 60,
  parameter T3_LONG_NS  = 160,
  parameter [7:0] ID_CODE = 8'h5A,  // Arbitrary value
  parameter [2:0] ID_REV  = 3'h0
) (
  // Clock and reset
  input  wire              CLK_SYS,
  input  wire              RST,
  // Backplane register port
  input  wire              QUALIFIER_HIGH,
  input  wire              QUALIFIER_LOW,
  input  wire              BYTE_QUALIFIER,
  input  wire              END_QUALIFIER,
  input  wire              UNIT_ADDRESS_QUALIFIER,
  input  wire              RD_STB,
  input  wire              WR_STB,
  input  wire [DATA_W-1:0] WR_DATA,
  output reg  [DATA_W-1:0] RD_DATA,
  input  wire              DEVICE_CLEAR,
  input  wire              SERVICE_REQUEST_POLL,
  output wire              POLL_RESPONSE,
  output wire              READY_FOR_COMMAND,
  output wire              DEVICE_BYTE_FLAG,
  output wire              DEVICE_END_FLAG,
  // Board switches and straps
  input  wire              LONG_CABLE_SEL,
  input  wire              PARITY_SW,
  input  wire              TEST_HOOD,
  // Peripheral side
  input  wire [DATA_W-1:0] PERIPH_DATA_IN,
  output reg  [DATA_W-1:0] PERIPH_DATA_OUT,
  output wire              HANDSHAKE_STROBE_OUT,
  input  wire              HANDSHAKE_FLAG_IN,
  output wire              TRANSFER_DIRECTION_OUT,
  input  wire [2:0]        PERIPHERAL_STATUS_LINES,
  output wire [2:0]        PERIPHERAL_CONTROL_LINES,
  input  wire              ATTENTION_INPUT
);

  // ================================================================
  // Delay counts, least times rounded up, at least one cycle
  localparam integer T1S_I = (T1_SHORT_NS + `PFCP_CLK_NS - 1) / `PFCP_CLK_NS;
  localparam integer T1L_I = (T1_LONG_NS  + `PFCP_CLK_NS - 1) / `PFCP_CLK_NS;
  localparam integer T2S_I = (T2_SHORT_NS + `PFCP_CLK_NS - 1) / `PFCP_CLK_NS;
  localparam integer T2L_I = (T2_LONG_NS  + `PFCP_CLK_NS - 1) / `PFCP_CLK_NS;
  localparam integer T3S_I = (T3_SHORT_NS + `PFCP_CLK_NS - 1) / `PFCP_CLK_NS;
  localparam integer T3L_I = (T3_LONG_NS  + `PFCP_CLK_NS - 1) / `PFCP_CLK_NS;
  localparam [7:0] T1S_C = (T1S_I < 1) ? 8'h01 : T1S_I[7:0];
  localparam [7:0] T1L_C = (T1L_I < 1) ? 8'h01 : T1L_I[7:0];
  localparam [7:0] T2S_C = (T2S_I < 1) ? 8'h01 : T2S_I[7:0];
  localparam [7:0] T2L_C = (T2L_I < 1) ? 8'h01 : T2L_I[7:0];
  localparam [7:0] T3S_C = (T3S_I < 1) ? 8'h01 : T3S_I[7:0];
  localparam [7:0] T3L_C = (T3L_I < 1) ? 8'h01 : T3L_I[7:0];
  // Handshake states, one-hot
  localparam [5:0] S_IDLE   = 6'h01;
  localparam [5:0] S_OSETUP = 6'h02;
  localparam [5:0] S_OWAIT  = 6'h04;
  localparam [5:0] S_IREADY = 6'h08;
  localparam [5:0] S_ILATCH = 6'h10;
  localparam [5:0] S_IHOLD  = 6'h20;
  // ================================================================
  // Registers
  reg              awake_ff;
  reg              are_ff;
  reg              arq_ff;
  reg  [7:0]       cc_ff;
  reg              flag_q_ff;
  reg              attention_input_q_ff;
  reg  [5:0]       st_ff;
  reg  [5:0]       nxt_st;
  reg  [7:0]       dly_ff;
  reg  [7:0]       nxt_dly;
  reg              strobe_ff;
  reg              nxt_strobe;
  reg  [DATA_W-1:0] mem_ff [0:FIFO_DEPTH-1];
  reg  [FIFO_AW-1:0] wp_ff;
  reg  [FIFO_AW-1:0] rp_ff;
  reg  [FIFO_AW:0]   cnt_ff;
  reg              per_push;
  reg              per_pop;

  // ================================================================
  // Decode and control fields
  wire [3:0] qual     = {QUALIFIER_HIGH, BYTE_QUALIFIER, END_QUALIFIER, QUALIFIER_LOW};
  wire sel_data       = ~QUALIFIER_HIGH & ~QUALIFIER_LOW;
  wire sel_status     = QUALIFIER_HIGH & QUALIFIER_LOW;
  wire rd_ok          = RD_STB & awake_ff;
  wire wr_ok          = WR_STB & awake_ff;
  wire wr_ctrl        = wr_ok & (qual == `PFCP_Q_CTRL);
  wire wr_card        = wr_ok & (qual == `PFCP_Q_CARD);
  wire dev_clr        = DEVICE_CLEAR | (wr_ctrl & WR_DATA[`PFCP_SC_DCL]);
  wire dir_in         = cc_ff[`PFCP_CC_DIR];
  wire edge_fall      = cc_ff[`PFCP_CC_EDG];
  wire fifo_clr       = cc_ff[`PFCP_CC_CLF];
  wire fp_off         = cc_ff[`PFCP_CC_PEN];
  wire run            = awake_ff & ~fifo_clr & ~fp_off;
  wire fifo_empty     = (cnt_ff == {(FIFO_AW+1){1'b0}});
  wire fifo_full      = (cnt_ff == FIFO_DEPTH[FIFO_AW:0]);
  wire [7:0] t1_c     = LONG_CABLE_SEL ? T1L_C : T1S_C;
  wire [7:0] t2_c     = LONG_CABLE_SEL ? T2L_C : T2S_C;
  wire [7:0] t3_c     = LONG_CABLE_SEL ? T3L_C : T3S_C;
  // Selected flag edge; both senses are derived from one stored sample
  wire flag_edge = edge_fall ? (flag_q_ff & ~HANDSHAKE_FLAG_IN)
                             : (~flag_q_ff & HANDSHAKE_FLAG_IN);
  // Host data moves only in the matching direction; misuse is dropped
  // here instead of corrupting pointers
  wire host_push = wr_ok & sel_data & ~dir_in & ~fifo_full;
  wire host_pop  = rd_ok & sel_data & dir_in & ~fifo_empty;
  wire push      = host_push | per_push;
  wire pop       = host_pop | per_pop;

  // ================================================================
  // Fixed backplane answers; orders have no path into the card at all
  assign READY_FOR_COMMAND = 1'b1;
  assign DEVICE_BYTE_FLAG  = 1'b0;
  assign DEVICE_END_FLAG   = 1'b0;
  // Poll answered only for data movement when the path can move a word
  assign POLL_RESPONSE = SERVICE_REQUEST_POLL & run & ~cc_ff[`PFCP_CC_PRN] &
                         (dir_in ? ~fifo_empty : ~fifo_full);
  // Peripheral side levels; control lines are inverted from program sense
  assign HANDSHAKE_STROBE_OUT     = strobe_ff;
  assign TRANSFER_DIRECTION_OUT   = ~dir_in;
  assign PERIPHERAL_CONTROL_LINES = ~cc_ff[`PFCP_CC_CL_MSB:0];

  // ================================================================
  // Wake latch: only a hard reset puts the card back to sleep
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      awake_ff <= 1'b0;
    end else if (WR_STB & sel_data & UNIT_ADDRESS_QUALIFIER) begin
      awake_ff <= 1'b1;
    end
  end

  // ================================================================
  // Control registers; undecoded writes fall through untouched
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cc_ff  <= `PFCP_CC_RESET;
      are_ff <= 1'b0;
    end else if (dev_clr) begin
      cc_ff  <= `PFCP_CC_RESET;
      are_ff <= 1'b0;
    end else begin
      if (wr_card) begin
        cc_ff <= WR_DATA[7:0];
      end
      if (wr_ctrl & WR_DATA[`PFCP_SC_ENA]) begin
        are_ff <= 1'b1;
      end else if (wr_ctrl & WR_DATA[`PFCP_SC_DIS]) begin
        are_ff <= 1'b0;
      end
    end
  end
  // ================================================================
  // Attention request: edge sensitive, cleared by status read or clear.
  // A new edge in the clearing cycle wins so no request is lost.
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      attention_input_q_ff <= 1'b0;
      arq_ff    <= 1'b0;
    end else begin
      attention_input_q_ff <= ATTENTION_INPUT;
      if (ATTENTION_INPUT & ~attention_input_q_ff) begin
        arq_ff <= 1'b1;
      end else if (dev_clr | (rd_ok & sel_status)) begin
        arq_ff <= 1'b0;
      end
    end
  end
  // ================================================================
  // Read data register; dormant or undecoded reads give zero
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RD_DATA <= {DATA_W{1'b0}};
    end else if (RD_STB) begin
      RD_DATA <= {DATA_W{1'b0}};
      if (awake_ff) begin
        if (sel_data) begin
          RD_DATA <= mem_ff[rp_ff];
        end else if (sel_status) begin
          RD_DATA <= `PFCP_STATUS_AES;
        end else if (qual == `PFCP_Q_SENSE) begin
          // Fixed bits carry ready-for-command and self-test pass
          RD_DATA <= `PFCP_SENSE_FIXED | ({15'h0000, are_ff} << `PFCP_SENSE_ARE)
                     | ({15'h0000, arq_ff} << `PFCP_SENSE_ARQ);
        end else if (qual == `PFCP_Q_IDENT) begin
          RD_DATA <= {8'h00, ID_CODE} | ({15'h0000, PARITY_SW} << `PFCP_ID_PE)
                     | ({13'h0000, ID_REV} << `PFCP_ID_REV_LSB);
        end else if (qual == `PFCP_Q_CARD) begin
          RD_DATA <= ({15'h0000, ~strobe_ff} << `PFCP_CS_PCL)
                     | ({15'h0000, HANDSHAKE_FLAG_IN} << `PFCP_CS_PFG)
                     | ({15'h0000, ~fifo_empty} << `PFCP_CS_OR)
                     | ({15'h0000, ~fifo_full} << `PFCP_CS_IR)
                     | ({15'h0000, TEST_HOOD} << `PFCP_CS_TES)
                     | {13'h0000, PERIPHERAL_STATUS_LINES};
        end
      end
    end
  end

  // ================================================================
  // FIFO storage, flip-flops without reset
  always @(posedge CLK_SYS) begin
    if (push) begin
      mem_ff[wp_ff] <= dir_in ? PERIPH_DATA_IN : WR_DATA;
    end
  end
  // FIFO pointers; the clear bit holds the path empty while set
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wp_ff  <= {FIFO_AW{1'b0}};
      rp_ff  <= {FIFO_AW{1'b0}};
      cnt_ff <= {(FIFO_AW+1){1'b0}};
    end else if (dev_clr | fifo_clr) begin
      wp_ff  <= {FIFO_AW{1'b0}};
      rp_ff  <= {FIFO_AW{1'b0}};
      cnt_ff <= {(FIFO_AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_ff <= wp_ff + {{(FIFO_AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_ff <= rp_ff + {{(FIFO_AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + {{FIFO_AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - {{FIFO_AW{1'b0}}, 1'b1};
      end
    end
  end

  // ================================================================
  // Handshake state machine. Edges are only looked at in states that
  // hold the strobe high, so stray edges cannot add or drop words.
  always @* begin
    nxt_st     = st_ff;
    nxt_dly    = dly_ff;
    nxt_strobe = strobe_ff;
    per_push   = 1'b0;
    per_pop    = 1'b0;
    case (st_ff)
      S_IDLE: begin
        nxt_strobe = 1'b0;
        if (run & dir_in & ~fifo_full) begin
          nxt_st     = S_IREADY;
          nxt_strobe = 1'b1;
        end else if (run & ~dir_in & ~fifo_empty) begin
          nxt_st  = S_OSETUP;
          nxt_dly = t1_c;
          per_pop = 1'b1;
        end
      end
      S_OSETUP: begin
        if (dly_ff == `PFCP_DLY_ONE) begin
          nxt_st     = S_OWAIT;
          nxt_strobe = 1'b1;
        end else begin
          nxt_dly = dly_ff - `PFCP_DLY_ONE;
        end
      end
      S_OWAIT: begin
        if (flag_edge) begin
          nxt_st     = S_IDLE;
          nxt_strobe = 1'b0;
        end
      end
      S_IREADY: begin
        if (flag_edge) begin
          nxt_st  = S_ILATCH;
          nxt_dly = t2_c;
        end
      end
      S_ILATCH: begin
        if (dly_ff == `PFCP_DLY_ONE) begin
          nxt_st     = S_IHOLD;
          nxt_dly    = t3_c;
          nxt_strobe = 1'b0;
          per_push   = ~fifo_full;
        end else begin
          nxt_dly = dly_ff - `PFCP_DLY_ONE;
        end
      end
      S_IHOLD: begin
        if (dly_ff != `PFCP_DLY_ONE) begin
          nxt_dly = dly_ff - `PFCP_DLY_ONE;
        end else if (~fifo_full) begin
          nxt_st     = S_IREADY;
          nxt_strobe = 1'b1;
        end
      end
      default: begin
        nxt_st     = S_IDLE;
        nxt_strobe = 1'b0;
      end
    endcase
    // Turning the frontplane off or clearing the path aborts any cycle
    if (~run) begin
      nxt_st     = S_IDLE;
      nxt_strobe = 1'b0;
      per_push   = 1'b0;
      per_pop    = 1'b0;
    end
  end
  // State, delay counter and strobe flip-flops
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_ff     <= S_IDLE;
      dly_ff    <= `PFCP_DLY_ONE;
      strobe_ff <= 1'b0;
      flag_q_ff <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      dly_ff    <= nxt_dly;
      strobe_ff <= nxt_strobe;
      flag_q_ff <= HANDSHAKE_FLAG_IN;
    end
  end
  // Output word register, msb straight to bit fifteen
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PERIPH_DATA_OUT <= {DATA_W{1'b0}};
    end else if (per_pop) begin
      PERIPH_DATA_OUT <= mem_ff[rp_ff];
    end
  end

endmodule // pfcp_card

// ===== rtl/pfcp_regs.vh
`ifndef PFCP_REGS_VH
`define PFCP_REGS_VH

// ==================================================================
// Qualifier codes {qualifier_high, byte_qualifier, end_qualifier, qualifier_low}
`define PFCP_Q_SENSE      4'h1
`define PFCP_Q_IDENT      4'h3
`define PFCP_Q_CARD       4'h7
`define PFCP_Q_CTRL       4'h1

// ==================================================================
// Sense register fixed layout
`define PFCP_SENSE_FIXED  16'h00C8
`define PFCP_SENSE_ARE    2
`define PFCP_SENSE_ARQ    0

// ==================================================================
// Standard control bits
`define PFCP_SC_DCL       5
`define PFCP_SC_ENA       1
`define PFCP_SC_DIS       0

// ==================================================================
// Standard status value (asynchronous event sensed)
`define PFCP_STATUS_AES   16'h0001

// ==================================================================
// Identity register fields
`define PFCP_ID_PE        11
`define PFCP_ID_REV_LSB   8

// ==================================================================
// Card control bits and reset value
`define PFCP_CC_PRN       7
`define PFCP_CC_DIR       6
`define PFCP_CC_EDG       5
`define PFCP_CC_CLF       4
`define PFCP_CC_PEN       3
`define PFCP_CC_CL_MSB    2
`define PFCP_CC_RESET     8'hFF

// ==================================================================
// Card status bits
`define PFCP_CS_PCL       7
`define PFCP_CS_PFG       6
`define PFCP_CS_OR        5
`define PFCP_CS_IR        4
`define PFCP_CS_TES       3

// ==================================================================
// Timing
`define PFCP_CLK_NS       20
`define PFCP_DLY_ONE      8'h01

`endif

// ===== tb/pfcp_props.sv
`timescale 1ns/10ps
`include "pfcp_regs.vh"
// ==================================================
// Port checker for the card
module pfcp_props #(
  parameter DATA_W = 16
) (
  // Clock and reset
  input wire              CLK_SYS,
  input wire              RST,
  // Register port
  input wire              QUALIFIER_HIGH,
  input wire              QUALIFIER_LOW,
  input wire              BYTE_QUALIFIER,
  input wire              END_QUALIFIER,
  input wire              UNIT_ADDRESS_QUALIFIER,
  input wire              RD_STB,
  input wire              WR_STB,
  input wire [DATA_W-1:0] RD_DATA,
  input wire              POLL_RESPONSE,
  input wire              SERVICE_REQUEST_POLL,
  input wire              READY_FOR_COMMAND,
  input wire              DEVICE_BYTE_FLAG,
  input wire              DEVICE_END_FLAG,
  // Peripheral side
  input wire [DATA_W-1:0] PERIPH_DATA_OUT,
  input wire              HANDSHAKE_STROBE_OUT,
  input wire              TRANSFER_DIRECTION_OUT,
  input wire [2:0]        PERIPHERAL_CONTROL_LINES
);
  wire [3:0] qsel;
  wire       nxt_awake;
  reg        awake_ff;
  // Wake tracking; device clear leaves the card awake, so only reset matters
  assign qsel = {QUALIFIER_HIGH, BYTE_QUALIFIER, END_QUALIFIER, QUALIFIER_LOW};
  assign nxt_awake = awake_ff | (WR_STB & ~qsel[3] & ~qsel[0] & UNIT_ADDRESS_QUALIFIER);
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) awake_ff <= 1'b0;
    else awake_ff <= nxt_awake;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Constant answers and poll gating
  chk_rfc_always: assert property (READY_FOR_COMMAND)
    else $error("ready for command dropped");
  chk_no_byte_end: assert property (!DEVICE_BYTE_FLAG && !DEVICE_END_FLAG)
    else $error("byte or end flag raised");
  chk_poll_gated: assert property (POLL_RESPONSE |-> SERVICE_REQUEST_POLL && awake_ff)
    else $error("poll answered without poll or while dormant");
  // Register reads and idle levels after reset
  chk_status_aes: assert property (RD_STB && qsel[3] && qsel[0] && awake_ff |=>
    RD_DATA == `PFCP_STATUS_AES) else $error("standard status wrong");
  chk_sense_fixed: assert property (
    RD_STB && qsel == `PFCP_Q_SENSE && awake_ff |=>
    (RD_DATA & 16'hFFFA) == `PFCP_SENSE_FIXED) else $error("sense fixed bits wrong");
  chk_dormant_reads: assert property (RD_STB && !awake_ff |=> RD_DATA == 16'h0000)
    else $error("dormant card answered a read");
  chk_reset_idle: assert property ($fell(RST) |-> !TRANSFER_DIRECTION_OUT &&
    !HANDSHAKE_STROBE_OUT && PERIPHERAL_CONTROL_LINES == 3'h0) else $error("not idle after reset");
  // Handshake timing; setup window is shorter than the smallest T1
  chk_out_setup: assert property (
    $rose(HANDSHAKE_STROBE_OUT) && TRANSFER_DIRECTION_OUT |->
    $stable(PERIPH_DATA_OUT) && $past(PERIPH_DATA_OUT, 5) == PERIPH_DATA_OUT)
    else $error("strobe rose before data settled");
  chk_in_low_time: assert property (
    $fell(HANDSHAKE_STROBE_OUT) && !TRANSFER_DIRECTION_OUT |=>
    !HANDSHAKE_STROBE_OUT [*2]) else $error("input strobe low pulse too short");
  // Main scenarios
  cov_out_word: cover property ($rose(HANDSHAKE_STROBE_OUT) && TRANSFER_DIRECTION_OUT);
  cov_in_word: cover property ($fell(HANDSHAKE_STROBE_OUT) && !TRANSFER_DIRECTION_OUT);
  cov_poll: cover property (POLL_RESPONSE);
endmodule // pfcp_props
bind pfcp_card pfcp_props #(.DATA_W(DATA_W)) i_pfcp_props (.CLK_SYS(CLK_SYS), .RST(RST),
  .QUALIFIER_HIGH(QUALIFIER_HIGH), .QUALIFIER_LOW(QUALIFIER_LOW),
  .BYTE_QUALIFIER(BYTE_QUALIFIER), .END_QUALIFIER(END_QUALIFIER),
  .UNIT_ADDRESS_QUALIFIER(UNIT_ADDRESS_QUALIFIER), .RD_STB(RD_STB), .WR_STB(WR_STB),
  .RD_DATA(RD_DATA), .POLL_RESPONSE(POLL_RESPONSE), .SERVICE_REQUEST_POLL(SERVICE_REQUEST_POLL),
  .READY_FOR_COMMAND(READY_FOR_COMMAND), .DEVICE_BYTE_FLAG(DEVICE_BYTE_FLAG),
  .DEVICE_END_FLAG(DEVICE_END_FLAG), .PERIPH_DATA_OUT(PERIPH_DATA_OUT),
  .HANDSHAKE_STROBE_OUT(HANDSHAKE_STROBE_OUT), .TRANSFER_DIRECTION_OUT(TRANSFER_DIRECTION_OUT),
  .PERIPHERAL_CONTROL_LINES(PERIPHERAL_CONTROL_LINES));

// ===== tb/pfcp_periph.sv
`timescale 1ns/10ps
// ==================================================
// Peripheral model: one flag pulse per card strobe
module pfcp_periph (
  // Control from bench
  input  wire        clk,
  input  wire        en,
  input  wire        inv,
  input  wire [3:0]  dly,
  input  wire [15:0] src,
  // Card side
  input  wire        dir,
  input  wire        stb,
  input  wire [15:0] dout,
  output wire        flag,
  output reg  [15:0] din
);
  reg        f_ff;
  reg [15:0] rx [0:31];
  integer    n;
  // Inverted cable flips the idle level of the flag
  assign flag = f_ff ^ inv;
  initial begin
    f_ff = 1'b0;
    din  = 16'h0000;
    n    = 0;
  end
  // Flag rises only while strobe is high and stays up until strobe drops
  always begin
    @(posedge clk);
    if (en && stb) begin
      if (!dir) din <= src ^ {n[7:0], ~n[7:0]};
      repeat (dly) @(posedge clk);
      if (dir) rx[n[4:0]] <= dout;
      n <= n + 1;
      f_ff <= 1'b1;
      while (stb) @(posedge clk);
      f_ff <= 1'b0;
      din <= ~din; // Released bus must not show the old word
    end
  end
endmodule // pfcp_periph

// ===== tb/test_parallel_fifo_card_port.sv
`timescale 1ns/10ps
`include "pfcp_regs.vh"
`define CHK(a, b) begin check_count = check_count + 1; if ((a) !== (b)) begin \
  mismatches = mismatches + 1; $display("BAD %0t got %h want %h", $time, (a), (b)); end end
// ==================================================
// Bench top
module test_parallel_fifo_card_port;
  reg         clk, rst, wr, rd, unit_address_qualifier, device_clear, service_request_poll, lng, par, hood, attention_input, en, inv;
  reg  [3:0]  qual, dly;
  reg  [2:0]  psl;
  reg  [15:0] wdat, src, r;
  reg  [15:0] wq [0:19];
  wire [15:0] rdat, pdi, pdo;
  wire [2:0]  pcl;
  wire        hs, flg, dir, poll;
  integer     seed, mismatches, check_count, cyc, i, k, n0;
  pfcp_card i_pfcp_card (.CLK_SYS(clk), .RST(rst), .QUALIFIER_HIGH(qual[3]),
    .BYTE_QUALIFIER(qual[2]), .END_QUALIFIER(qual[1]), .QUALIFIER_LOW(qual[0]),
    .UNIT_ADDRESS_QUALIFIER(unit_address_qualifier), .RD_STB(rd), .WR_STB(wr), .WR_DATA(wdat), .RD_DATA(rdat),
    .DEVICE_CLEAR(device_clear), .SERVICE_REQUEST_POLL(service_request_poll), .POLL_RESPONSE(poll),
    .READY_FOR_COMMAND(), .DEVICE_BYTE_FLAG(), .DEVICE_END_FLAG(), .LONG_CABLE_SEL(lng),
    .PARITY_SW(par), .TEST_HOOD(hood), .PERIPH_DATA_IN(pdi), .PERIPH_DATA_OUT(pdo),
    .HANDSHAKE_STROBE_OUT(hs), .HANDSHAKE_FLAG_IN(flg), .TRANSFER_DIRECTION_OUT(dir),
    .PERIPHERAL_STATUS_LINES(psl), .PERIPHERAL_CONTROL_LINES(pcl), .ATTENTION_INPUT(attention_input));
  pfcp_periph i_pfcp_periph (.clk(clk), .en(en), .inv(inv), .dly(dly), .src(src), .dir(dir),
    .stb(hs), .dout(pdo), .flag(flg), .din(pdi));
  // Expected word number k from the peripheral
  function [15:0] exp_in(input integer k);
    exp_in = src ^ {k[7:0], ~k[7:0]};
  endfunction
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  // One register access; read data is taken the cycle after the strobe
  task bus(input w, input [3:0] q, input [15:0] d);
    begin
      @(negedge clk);
      qual = q;
      wdat = d;
      wr = w;
      rd = !w;
      @(negedge clk);
      r = rdat;
      wr = 1'b0;
      rd = 1'b0;
    end
  endtask
  // Data is touched only while the card answers the poll
  task wait_poll;
    begin
      for (k = 0; k < 500 && poll !== 1'b1; k = k + 1) @(negedge clk);
      `CHK(poll, 1'b1)
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end
  initial begin
    seed = 33;
    mismatches = 0;
    check_count = 0;
    cyc = 0;
    {rst, wr, rd, unit_address_qualifier, device_clear, service_request_poll, attention_input, en, inv, qual, dly, wdat} = {1'b1, 32'h0};
    {lng, par, hood, psl} = 6'($random(seed));
    src = 16'($random(seed));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    // ==================================================
    // Dormant, wake and read decode
    bus(0, `PFCP_Q_SENSE, 16'h0000);
    `CHK(r, 16'h0000)
    unit_address_qualifier = 1'b1;
    bus(1, 4'h0, 16'h0000);
    unit_address_qualifier = 1'b0;
    bus(0, `PFCP_Q_SENSE, 16'h0000);
    `CHK(r, `PFCP_SENSE_FIXED)
    bus(0, `PFCP_Q_IDENT, 16'h0000);
    `CHK(r, {4'h0, par, 3'h0, 8'h5A})
    bus(0, `PFCP_Q_CARD, 16'h0000);
    `CHK(r[7:0], {4'h9, hood, psl})
    for (i = 0; i < 4; i = i + 1) begin
      bus(0, {1'b1, i[1:0], 1'b1}, 16'h0000);
      `CHK(r, `PFCP_STATUS_AES)
    end
    bus(0, 4'h5, 16'h0000); // Undecoded read, value is free
    $display("test decode done");
    // ==================================================
    // Request flag and interrupt enable
    attention_input = 1'b1;
    repeat (4) @(negedge clk);
    bus(0, `PFCP_Q_SENSE, 16'h0000);
    `CHK(r[`PFCP_SENSE_ARQ], 1'b1)
    bus(0, 4'h9, 16'h0000);
    bus(0, `PFCP_Q_SENSE, 16'h0000);
    `CHK(r[`PFCP_SENSE_ARQ], 1'b0)
    attention_input = 1'b0;
    for (i = 0; i < 2; i = i + 1) begin
      bus(1, `PFCP_Q_CTRL, i ? 16'h0001 : 16'h0002);
      bus(0, `PFCP_Q_SENSE, 16'h0000);
      `CHK(r[`PFCP_SENSE_ARE], i == 0)
    end
    $display("test request done");
    // ==================================================
    // Undecoded writes, then both ways of clearing
    for (i = 0; i < 2; i = i + 1) begin
      bus(1, `PFCP_Q_CARD, 16'h0000);
      bus(1, 4'h3, 16'h00FF);
      bus(1, 4'hB, 16'h00FF);
      `CHK({dir, pcl}, 4'hF)
      if (i == 0) bus(1, `PFCP_Q_CTRL, 16'h0020);
      else begin
        device_clear = 1'b1;
        @(negedge clk);
        device_clear = 1'b0;
        @(negedge clk);
      end
      `CHK({dir, pcl, hs}, 5'h00)
    end
    $display("test clear done");
    // ==================================================
    // Output stream, rising edge, slow and fast peripheral
    en = 1'b1;
    bus(1, `PFCP_Q_CARD, 16'h00BF);
    bus(1, `PFCP_Q_CARD, 16'h0087);
    service_request_poll = 1'b1;
    @(negedge clk);
    `CHK(poll, 1'b0)
    bus(1, `PFCP_Q_CARD, 16'h0007);
    for (i = 0; i < 20; i = i + 1) begin
      wq[i] = i ? 16'($random(seed)) : 16'h8000;
      dly = 4'($random(seed));
      wait_poll;
      bus(1, 4'h0, wq[i]);
    end
    for (k = 0; k < 3000 && i_pfcp_periph.n != 20; k = k + 1) @(negedge clk);
    for (i = 0; i < 20; i = i + 1) `CHK(i_pfcp_periph.rx[i], wq[i])
    $display("test output done");
    // ==================================================
    // Input stream on falling edge through an inverted cable, fill then drain
    en = 1'b0;
    bus(1, `PFCP_Q_CARD, 16'h00FF);
    inv = 1'b1;
    n0 = i_pfcp_periph.n;
    bus(1, `PFCP_Q_CARD, 16'h0067);
    repeat (2) @(negedge clk);
    `CHK(hs, 1'b1)
    en = 1'b1;
    dly = 4'($random(seed));
    for (k = 0; k < 3000 && i_pfcp_periph.n != n0 + 16; k = k + 1) @(negedge clk);
    repeat (60) @(negedge clk);
    `CHK({i_pfcp_periph.n - n0, hs}, {32'd16, 1'b0})
    bus(0, `PFCP_Q_CARD, 16'h0000);
    `CHK(r[5:4], 2'b10)
    for (i = 0; i < 20; i = i + 1) begin
      wait_poll;
      bus(0, 4'h0, 16'h0000);
      `CHK(r, exp_in(n0 + i))
    end
    $display("test input done");
    // ==================================================
    // Second reset puts the card back to sleep
    en = 1'b0;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    bus(0, `PFCP_Q_SENSE, 16'h0000);
    `CHK(r, 16'h0000)
    $display("test rereset done");
    give_verdict;
  end
endmodule // test_parallel_fifo_card_port
